// ---- logic/alias_update.sv ----
// Purpose: next value of one register under plain, clear, set, invert
// Assumes: combinational, used once per aliased register
// Notes:   only bits in the writable mask can change
`timescale 1ns/1ps
`default_nettype none
module alias_update
(
	// current value and write request
	input  wire logic [31:0]          cur,
	input  wire logic [31:0]          wdata,
	input  wire logic [31:0]          mask,
	input  wire ram_part_pkg::alias_op_t op,
	// result
	output logic      [31:0]          nxt
);

	logic [31:0] raw;

	// apply the alias operation, then keep fixed bits at zero
	always_comb
	begin
		case (op)
			ram_part_pkg::OP_CLR:   raw = cur & ~wdata;
			ram_part_pkg::OP_SET:   raw = cur | wdata;
			ram_part_pkg::OP_INV:   raw = cur ^ wdata;
			ram_part_pkg::OP_WRITE: raw = wdata;
			default:                raw = cur;
		endcase
		nxt = raw & mask;
	end

endmodule : alias_update
`default_nettype wire

// ---- logic/ram_part_pkg.sv ----
// Purpose: constants and types for the RAM partition register set
// Assumes: APB slave, 32-bit data, byte addresses
// Notes:   sizes of RAM, flash and boot flash are plain defaults
package ram_part_pkg;

	// -------------------------------------------------------------
	// address map
	// -------------------------------------------------------------
	localparam int          ADDR_W            = 16;
	localparam logic [15:0] OFS_MATRIX_CONFIG = 16'h2000;
	localparam logic [15:0] OFS_KERNEL_PROG   = 16'h2010;
	localparam logic [15:0] OFS_USER_DATA     = 16'h2020;
	localparam logic [15:0] OFS_USER_PROG     = 16'h2030;
	localparam logic [15:0] OFS_RAM_SIZE      = 16'h2040;
	localparam logic [15:0] OFS_FLASH_USER    = 16'h2050;
	localparam logic [15:0] OFS_FLASH_SIZE    = 16'h2060;
	localparam logic [15:0] OFS_BOOT_SIZE     = 16'h2070;
	localparam logic [15:0] BLOCK_MASK        = 16'hFFF0;
	localparam logic [3:0]  ALIAS_PLAIN       = 4'h0;
	localparam logic [3:0]  ALIAS_CLR         = 4'h4;
	localparam logic [3:0]  ALIAS_SET         = 4'h8;
	localparam logic [3:0]  ALIAS_INV         = 4'hC;

	// -------------------------------------------------------------
	// field layouts and reset values
	// -------------------------------------------------------------
	localparam logic [31:0] KERNEL_PROG_MASK = 32'h0000_FC00;
	localparam logic [31:0] USER_BASE_MASK   = 32'h0000_FFFF;
	localparam logic [31:0] FLASH_USER_MASK  = 32'h000F_FFFF;
	localparam logic [31:0] BASE_RESET       = 32'h0000_0000;
	localparam logic [31:0] MATRIX_CFG_VALUE = 32'h0000_0000;
	localparam logic [31:0] RAM_SIZE_VALUE   = 32'h0000_4000;
	localparam logic [31:0] FLASH_SIZE_VALUE = 32'h0002_0000;
	localparam logic [31:0] BOOT_SIZE_VALUE  = 32'h0000_0C00;
	localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0]
	{
		OP_WRITE = 2'h0,
		OP_CLR   = 2'h1,
		OP_SET   = 2'h3,
		OP_INV   = 2'h2
	} alias_op_t;

	typedef struct packed
	{
		logic [31:0] kernel_prog_base;
		logic [31:0] user_data_base;
		logic [31:0] user_prog_base;
		logic [31:0] flash_user_base;
		logic        kernel_prog_on;
	} partition_t;

endpackage : ram_part_pkg

// ---- logic/ram_partition_base_regs.sv ----
// Purpose: bus matrix register set splitting RAM into kernel/user
// Assumes: APB slave on clock, asynchronous active-low reset
// Notes:   answers every transfer with one wait-free access cycle
//
// How it works
// - A non-zero upper base field marks where kernel program RAM starts.
// - Kernel base bits 9 to 0 read zero and are never stored, giving 1 KB steps.
// - Reset clears the kernel program base so all RAM is kernel data.
// - Kernel and user base bits 31 to 16 read back as zero; flash user base bits 31 to 20.
// - Aliased registers take clear, set, invert writes at +4, +8, +12.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ram_partition_base_regs
(
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      nrst,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [15:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic                           pready,
	output logic      [31:0]               prdata,
	output logic                           pslverr,
	// partition outputs to the bus matrix
	output ram_part_pkg::partition_t       partition
);

	// -------------------------------------------------------------
	// storage
	// -------------------------------------------------------------
	logic [31:0]             kernel_prog_q;
	logic [31:0]             user_data_q;
	logic [31:0]             user_prog_q;
	logic [31:0]             flash_user_q;
	logic                    pready_q;
	logic [31:0]             prdata_q;
	logic                    pslverr_q;
	ram_part_pkg::partition_t partition_q;

	// -------------------------------------------------------------
	// decode
	// -------------------------------------------------------------
	logic [15:0]             blk;
	logic [3:0]              sub;
	logic                    setup;
	logic                    commit;
	logic                    aliased;
	logic                    hit;
	ram_part_pkg::alias_op_t op;
	logic [31:0]             rd_d;
	logic [31:0]             kernel_prog_d;
	logic [31:0]             flash_user_d;

	assign blk    = paddr & ram_part_pkg::BLOCK_MASK;
	assign sub    = paddr[3:0];
	assign setup  = psel && !penable && !pready_q;
	assign commit = psel && penable && pready_q && pwrite && hit;

	// alias decode; only kernel program and flash user bases have aliases
	always_comb
	begin
		aliased = (blk == ram_part_pkg::OFS_KERNEL_PROG) ||
		          (blk == ram_part_pkg::OFS_FLASH_USER);
		case (sub)
			ram_part_pkg::ALIAS_CLR: op = ram_part_pkg::OP_CLR;
			ram_part_pkg::ALIAS_SET: op = ram_part_pkg::OP_SET;
			ram_part_pkg::ALIAS_INV: op = ram_part_pkg::OP_INV;
			default:                 op = ram_part_pkg::OP_WRITE;
		endcase
		if (aliased)
			hit = (sub == ram_part_pkg::ALIAS_PLAIN) ||
			      (sub == ram_part_pkg::ALIAS_CLR) ||
			      (sub == ram_part_pkg::ALIAS_SET) ||
			      (sub == ram_part_pkg::ALIAS_INV);
		else
			hit = (sub == ram_part_pkg::ALIAS_PLAIN) &&
			      ((blk == ram_part_pkg::OFS_MATRIX_CONFIG) ||
			       (blk == ram_part_pkg::OFS_USER_DATA) ||
			       (blk == ram_part_pkg::OFS_USER_PROG) ||
			       (blk == ram_part_pkg::OFS_RAM_SIZE) ||
			       (blk == ram_part_pkg::OFS_FLASH_SIZE) ||
			       (blk == ram_part_pkg::OFS_BOOT_SIZE));
	end

	// read mux; alias addresses read as the base register
	always_comb
	begin
		case (blk)
			ram_part_pkg::OFS_MATRIX_CONFIG: rd_d = ram_part_pkg::MATRIX_CFG_VALUE;
			ram_part_pkg::OFS_KERNEL_PROG:   rd_d = kernel_prog_q;
			ram_part_pkg::OFS_USER_DATA:     rd_d = user_data_q;
			ram_part_pkg::OFS_USER_PROG:     rd_d = user_prog_q;
			ram_part_pkg::OFS_RAM_SIZE:      rd_d = ram_part_pkg::RAM_SIZE_VALUE;
			ram_part_pkg::OFS_FLASH_USER:    rd_d = flash_user_q;
			ram_part_pkg::OFS_FLASH_SIZE:    rd_d = ram_part_pkg::FLASH_SIZE_VALUE;
			ram_part_pkg::OFS_BOOT_SIZE:     rd_d = ram_part_pkg::BOOT_SIZE_VALUE;
			default:                         rd_d = ram_part_pkg::READ_ZERO;
		endcase
	end

	// -------------------------------------------------------------
	// alias arithmetic
	// -------------------------------------------------------------
	alias_update u_kernel_upd
	(
		.cur   (kernel_prog_q),
		.wdata (pwdata),
		.mask  (ram_part_pkg::KERNEL_PROG_MASK),
		.op    (op),
		.nxt   (kernel_prog_d)
	);

	alias_update u_flash_upd
	(
		.cur   (flash_user_q),
		.wdata (pwdata),
		.mask  (ram_part_pkg::FLASH_USER_MASK),
		.op    (op),
		.nxt   (flash_user_d)
	);

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------

	// kernel program base, 1 KB granular, cleared on reset
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			kernel_prog_q <= ram_part_pkg::BASE_RESET;
		else if (commit && blk == ram_part_pkg::OFS_KERNEL_PROG)
			kernel_prog_q <= kernel_prog_d;
	end

	// flash user program base with aliases
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			flash_user_q <= ram_part_pkg::BASE_RESET;
		else if (commit && blk == ram_part_pkg::OFS_FLASH_USER)
			flash_user_q <= flash_user_d;
	end

	// user data and user program bases, plain writes only
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			user_data_q <= ram_part_pkg::BASE_RESET;
			user_prog_q <= ram_part_pkg::BASE_RESET;
		end
		else if (commit && blk == ram_part_pkg::OFS_USER_DATA)
			user_data_q <= pwdata & ram_part_pkg::USER_BASE_MASK;
		else if (commit && blk == ram_part_pkg::OFS_USER_PROG)
			user_prog_q <= pwdata & ram_part_pkg::USER_BASE_MASK;
	end

	// -------------------------------------------------------------
	// apb answer
	// -------------------------------------------------------------

	// ready in the first access cycle, data latched at setup
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= ram_part_pkg::READ_ZERO;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			pready_q  <= 1'b1;
			prdata_q  <= (hit && !pwrite) ? rd_d : ram_part_pkg::READ_ZERO;
			pslverr_q <= !hit;  // unmapped address
		end
		else
		begin
			pready_q  <= 1'b0;
			prdata_q  <= ram_part_pkg::READ_ZERO;
			pslverr_q <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// partition outputs
	// -------------------------------------------------------------

	// registered copy of the bases for the bus matrix
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			partition_q.kernel_prog_base <= ram_part_pkg::BASE_RESET;
			partition_q.user_data_base   <= ram_part_pkg::BASE_RESET;
			partition_q.user_prog_base   <= ram_part_pkg::BASE_RESET;
			partition_q.flash_user_base  <= ram_part_pkg::BASE_RESET;
			partition_q.kernel_prog_on   <= 1'b0;
		end
		else
		begin
			partition_q.kernel_prog_base <= kernel_prog_q;
			partition_q.user_data_base   <= user_data_q;
			partition_q.user_prog_base   <= user_prog_q;
			partition_q.flash_user_base  <= flash_user_q;
			partition_q.kernel_prog_on   <= |kernel_prog_q;
		end
	end

	assign pready    = pready_q;
	assign prdata    = prdata_q;
	assign pslverr   = pslverr_q;
	assign partition = partition_q;

endmodule : ram_partition_base_regs
`default_nettype wire

// ---- tb/ram_partition_base_regs_checker.sv ----
// Purpose: concurrent checks on the RAM partition register set
// Assumes: one clock domain, nrst asynchronous and active low
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ram_part_checker
(
	// clock and reset
	input wire logic                     clock,
	input wire logic                     nrst,
	// apb slave
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [15:0]              paddr,
	input wire logic [31:0]              pwdata,
	input wire logic                     pready,
	input wire logic [31:0]              prdata,
	input wire logic                     pslverr,
	// partition outputs
	input wire ram_part_pkg::partition_t partition
);
	// ----------------------------------------------------------
	// kernel base and pready timing checks
	// ----------------------------------------------------------
	localparam logic [31:0] KM = ram_part_pkg::KERNEL_PROG_MASK;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// base as seen by the bus matrix
	wire logic [31:0] kbase = partition.kernel_prog_base;
	sequence s_commit(logic [15:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	property p_plain;
		s_commit(16'h2010) |-> ##2 kbase == ($past(pwdata, 2) & KM);
	endproperty
	property p_clr;
		s_commit(16'h2014) |-> ##2 kbase == ($past(kbase, 2) & ~$past(pwdata, 2));
	endproperty
	property p_set;
		s_commit(16'h2018) |-> ##2
			kbase == ($past(kbase, 2) | ($past(pwdata, 2) & KM));
	endproperty
	property p_inv;
		s_commit(16'h201C) |-> ##2
			kbase == ($past(kbase, 2) ^ ($past(pwdata, 2) & KM));
	endproperty
	property p_on;
		partition.kernel_prog_on == (kbase != 32'h0000_0000);
	endproperty
	property p_read;
		pready && !pwrite && paddr == 16'h2010 |->
			prdata == kbase && (prdata & ~KM) == 32'h0000_0000;
	endproperty
	property p_reset;
		$rose(nrst) |-> ##1 kbase == 32'h0000_0000;
	endproperty
	property p_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_plain: assert property (p_plain) else $error("plain write wrong");
	a_clr: assert property (p_clr) else $error("clear alias wrong");
	a_set: assert property (p_set) else $error("set alias wrong");
	a_inv: assert property (p_inv) else $error("invert alias wrong");
	a_on: assert property (p_on) else $error("kernel enable wrong");
	a_read: assert property (p_read) else $error("base read wrong");
	a_reset: assert property (p_reset) else $error("base not cleared");
	a_ready: assert property (p_ready) else $error("pready timing wrong");
endmodule : ram_part_checker
bind ram_partition_base_regs ram_part_checker chk_u (.clock(clock),
	.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .partition(partition));
`default_nettype wire

// ---- tb/test_ram_partition_base_regs.sv ----
// Purpose: self-checking bench for the RAM partition register set
// Assumes: APB master, one transfer at a time
// Notes:   random alias traffic on the kernel base
`timescale 1ns/1ps
`default_nettype none
module test_ram_partition_base_regs;
	logic                     clock = 1'b0;
	logic                     nrst = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [15:0]              paddr = 16'h0000;
	logic [31:0]              pwdata = 32'h0000_0000;
	logic                     pready, pslverr, err;
	logic [31:0]              prdata, rd, kb, d, fv, wv;
	ram_part_pkg::partition_t partition;
	int                       fails = 0, tests_run = 0, cycles = 0, op;
	logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h0,
		ram_part_pkg::RAM_SIZE_VALUE, 32'h0,
		ram_part_pkg::FLASH_SIZE_VALUE, ram_part_pkg::BOOT_SIZE_VALUE};
	logic [31:0] wm [8] = '{32'h0, ram_part_pkg::KERNEL_PROG_MASK,
		ram_part_pkg::USER_BASE_MASK, ram_part_pkg::USER_BASE_MASK, 32'h0,
		ram_part_pkg::FLASH_USER_MASK, 32'h0, 32'h0};

	ram_partition_base_regs dut_u (.clock(clock), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.partition(partition));

	// clock and hang guard
	always #4 clock = ~clock;
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fails++;
			conclude();
		end
	end

	// verdict and end of run
	task automatic conclude();
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// one value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, request held until pready
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] v);
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= v;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// reset held three cycles
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
	endtask : do_reset

	// expected base after plain, clear, set, invert
	function automatic logic [31:0] nxt(int i, logic [31:0] c,
		logic [31:0] v, logic [31:0] mk);
		logic [31:0] m;
		m = v & mk;
		case (i)
			0: return m;
			1: return c & ~m;
			2: return c | m;
			default: return c ^ m;
		endcase
	endfunction : nxt

	// main sequence
	initial
	begin
		void'($urandom(32'h73A62FE4));
		do_reset();
		for (int i = 0; i < 8; i++)
		begin
			// kernel base stays within the ram size
			wv = (i == 1) ? 32'hFFFF_43FF : 32'hFFFF_FFFF;
			apb(1'b0, 16'h2000 + 16'(i * 16), 32'h0);
			chk(rd, rv[i]);
			apb(1'b1, 16'h2000 + 16'(i * 16), wv);
			chk(rd, 32'h0000_0000);
			apb(1'b0, 16'h2000 + 16'(i * 16), 32'h0);
			chk(rd, rv[i] | (wm[i] & wv));
			chk({31'h0, err}, 32'h0000_0000);
		end
		chk(partition.user_data_base, ram_part_pkg::USER_BASE_MASK);
		chk(partition.user_prog_base, ram_part_pkg::USER_BASE_MASK);
		kb = 32'hFFFF_43FF & ram_part_pkg::KERNEL_PROG_MASK;
		fv = ram_part_pkg::FLASH_USER_MASK;
		for (int k = 0; k < 60; k++)
		begin
			op = (k < 2) ? k : $urandom % 4;
			d = (k < 2) ? 32'hFFFF_43FF : ($urandom & 32'hFFFF_3FFF);
			// fall back to a clear when the result would pass ram size
			if (nxt(op, kb, d, ram_part_pkg::KERNEL_PROG_MASK) >
				ram_part_pkg::RAM_SIZE_VALUE)
				op = 1;
			apb(1'b1, 16'h2010 + 16'(op * 4), d);
			kb = nxt(op, kb, d, ram_part_pkg::KERNEL_PROG_MASK);
			apb(1'b0, 16'h2010, 32'h0);
			chk(rd, kb);
			chk(partition.kernel_prog_base, kb);
			chk({31'h0, partition.kernel_prog_on}, {31'h0, kb != 0});
			// flash user base aliases, read back through the alias
			op = $urandom % 4;
			d = $urandom;
			apb(1'b1, 16'h2050 + 16'(op * 4), d);
			fv = nxt(op, fv, d, ram_part_pkg::FLASH_USER_MASK);
			apb(1'b0, 16'h2050 + 16'(op * 4), 32'h0);
			chk(rd, fv);
			chk(partition.flash_user_base, fv);
		end
		apb(1'b0, 16'h2024, 32'h0);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		// unmapped write must leave the user data base alone
		apb(1'b1, 16'h2024, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b0, 16'h2020, 32'h0);
		chk(rd, ram_part_pkg::USER_BASE_MASK);
		// non-zero base before the mid-run reset
		apb(1'b1, 16'h2010, 32'h0000_4000);
		do_reset();
		apb(1'b0, 16'h2010, 32'h0);
		chk(rd, 32'h0000_0000);
		chk(partition.kernel_prog_base, 32'h0000_0000);
		chk(partition.flash_user_base, 32'h0000_0000);
		conclude();
	end
endmodule : test_ram_partition_base_regs
`default_nettype wire
